// ===== rtl/fcc_flash_regs.vh
`ifndef FCC_FLASH_REGS_VH
`define FCC_FLASH_REGS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FCC_OFS_DIV        8'h00
`define FCC_OFS_PROT       8'h04
`define FCC_OFS_STAT       8'h08
`define FCC_OFS_CMD        8'h0C
`define FCC_OFS_ADDR       8'h10
`define FCC_OFS_DATA       8'h14
`define FCC_OFS_INT_STAT   8'h18
`define FCC_OFS_INT_MASK   8'h1C

// ****************************************************************
// field positions
// ****************************************************************
`define FCC_PROT_DIS_BIT   0
`define FCC_ST_CBEF_BIT    7
`define FCC_ST_CCF_BIT     6
`define FCC_ST_PVIOL_BIT   5
`define FCC_ST_ACCERR_BIT  4
`define FCC_ST_BLANK_BIT   2
`define FCC_INT_CCF_BIT    0
`define FCC_INT_PVIOL_BIT  1
`define FCC_INT_ACC_BIT    2

// ****************************************************************
// reset values
// ****************************************************************
`define FCC_RST_PROT       8'hFF
`define FCC_RST_DIV        7'h00
`define FCC_RST_CMD        8'h00
`define FCC_RST_MASK       3'h0

// ****************************************************************
// command codes
// ****************************************************************
`define FCC_BLANK_CHECK_CODE   8'h05
`define FCC_BYTE_PROGRAM_CODE  8'h20
`define FCC_BURST_PROGRAM_CODE 8'h25
`define FCC_PAGE_ERASE_CODE    8'h40
`define FCC_MASS_ERASE_CODE    8'h41
`define FCC_ERASED_BYTE        8'hFF

// ****************************************************************
// timing counts in divided flash clock ticks
// ****************************************************************
`define FCC_T_PROG_STD     16'h0009
`define FCC_T_PROG_BURST   16'h0004
`define FCC_T_PAGE_ERASE   16'h0FA0
`define FCC_T_MASS_ERASE   16'h4E20

`endif

// ===== rtl/fcc_flash_command_controller.v
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "fcc_flash_regs.vh"

// Notes on behaviour
// (RL1) a burst chain gives its first byte the standard program time and each following sequential byte in the same row the burst time.
// (RL2) a sequential burst byte that opens a new row drops array high voltage for a cycle and takes the standard time.
// (RL3) with no burst command queued when the running one ends, the charge pump and array high voltage go off.
// (RL4) while protection is on, the 7-bit select field in bits 7:1 marks the top of the unprotected space and higher locations refuse program and erase.
// (RL5) protection bit 0 at one protects nothing, at zero the selected block is protected.
// (RL6) software launches by writing one to status bit 7, and the device sets the buffer free again when it hands a buffered burst to the array.
// (RL7) only burst program commands are buffered, and bit 7 reads one while another burst may be written and zero while the buffer is full.
// (RL8) status bit 6 is set while the buffer is empty and nothing runs, clears on a launch and ignores writes.
// (RL9) a launch aimed at a protected location sets status bit 5 and is dropped, and writing one clears that bit.
// (RL10) a broken sequence, a program or erase before the divider is set, or stop during a command sets status bit 4 and drops the command, cleared by writing one.
// (RL11) a blank check that finds every byte erased sets status bit 2, which clears on the next valid launch and ignores writes.
// (RL12) code 05 is blank check, 20 is byte program and 25 is burst program.
// (RL13) code 40 erases one 512-byte page and 41 erases the whole array.
// (RL14) every other command code is illegal and raises an access error.
// (RL15) software needs no blank check after a mass erase, only as part of unlocking security.
// (RL16) software writes address and data, then the command code, then launches.
module fcc_flash_command_controller
#(
  parameter ARRAY_BYTES = 8192,
  parameter ROW_BITS    = 6,
  parameter T_PAGE      = `FCC_T_PAGE_ERASE,
  parameter T_MASS      = `FCC_T_MASS_ERASE
)
(
  input  wire        i_clk_sys,
  input  wire        i_rst_b,
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  input  wire        i_stop_req,
  input  wire [7:0]  i_array_rdata,
  output reg  [15:0] o_array_addr,
  output reg  [7:0]  o_array_wdata,
  output reg         o_array_prog,
  output reg         o_array_erase,
  output reg         o_array_mass,
  output reg         o_hv_on,
  output reg         o_pump_on,
  output reg         o_irq
);

  // ****************************************************************
  // states
  // ****************************************************************
  localparam ST_IDLE  = 2'd0;
  localparam ST_RUN   = 2'd1;
  localparam ST_GAP   = 2'd2;
  localparam ST_BLANK = 2'd3;
  localparam [15:0] T_STD   = `FCC_T_PROG_STD;
  localparam [15:0] T_BURST = `FCC_T_PROG_BURST;
  localparam integer LAST_I = ARRAY_BYTES - 1;
  localparam [15:0] LAST_A  = LAST_I[15:0];

  reg  [6:0]  div_reg;
  reg         div_init_reg;
  reg  [6:0]  div_cnt_reg;
  reg         tick_reg;
  reg  [7:0]  prot_reg;
  reg  [7:0]  cmd_reg;
  reg         cmd_wr_reg;
  reg  [15:0] addr_reg;
  reg  [7:0]  data_reg;
  reg         cbef_reg;
  reg         ccf_reg;
  reg         pviol_reg;
  reg         accerr_reg;
  reg         blank_reg;
  reg         buf_valid_reg;
  reg  [15:0] buf_addr_reg;
  reg  [7:0]  buf_data_reg;
  reg  [1:0]  state_reg;
  reg  [7:0]  act_cmd_reg;
  reg  [15:0] timer_reg;
  reg         scan_pend_reg;
  reg         scan_last_reg;
  reg         scan_ok_reg;
  reg  [2:0]  int_stat_reg;
  reg  [2:0]  int_mask_reg;
  reg  [7:0]  rd_val;

  // ****************************************************************
  // bus strobes and launch checks
  // ****************************************************************
  wire       wr_do  = o_awready & i_awvalid & i_wvalid;
  wire       we     = wr_do & i_wstrb[0];
  wire [7:0] wd     = i_wdata[7:0];
  wire       rd_do  = o_arready & i_arvalid;
  wire       idle   = (state_reg == ST_IDLE);
  wire       w_stat = we & (i_awaddr == `FCC_OFS_STAT);
  wire       w_seq  = we & ((i_awaddr == `FCC_OFS_CMD) |
                (i_awaddr == `FCC_OFS_ADDR) | (i_awaddr == `FCC_OFS_DATA));
  wire       launch = w_stat & wd[`FCC_ST_CBEF_BIT] & cbef_reg; // RL6
  wire       is_blank = (cmd_reg == `FCC_BLANK_CHECK_CODE);    // RL12
  wire       is_byte  = (cmd_reg == `FCC_BYTE_PROGRAM_CODE);   // RL12
  wire       is_burst = (cmd_reg == `FCC_BURST_PROGRAM_CODE);  // RL12
  wire       is_page  = (cmd_reg == `FCC_PAGE_ERASE_CODE);     // RL13
  wire       is_mass  = (cmd_reg == `FCC_MASS_ERASE_CODE);     // RL13
  wire       legal  = is_blank | is_byte | is_burst | is_page | is_mass;
  wire       prot_on = ~prot_reg[`FCC_PROT_DIS_BIT];           // RL5
  wire       prot_hit = prot_on & ~is_blank &
                        (is_mass | (addr_reg[15:9] > prot_reg[7:1])); // RL4
  wire       can_queue = (act_cmd_reg == `FCC_BURST_PROGRAM_CODE) &
                         is_burst & ~buf_valid_reg & ~idle;    // RL7
  wire       bad_acc = ~cmd_wr_reg | ~legal |                  // RL14
                       (~is_blank & ~div_init_reg) |
                       (~idle & ~can_queue);                   // RL10
  wire       set_acc = (launch & bad_acc) | (w_seq & ~cbef_reg) |
                       (i_stop_req & ~idle);                   // RL10
  wire       set_pv  = launch & ~bad_acc & prot_hit;           // RL9
  wire       go      = launch & ~bad_acc & ~prot_hit;
  wire       run_end = (state_reg == ST_RUN) & tick_reg &
                       (timer_reg == 16'h0001);
  wire [15:0] nxt_a  = o_array_addr + 16'h0001;
  // a burst queued on the very edge the running byte ends still chains
  wire       q_take  = go & ~idle;
  wire       q_valid = buf_valid_reg | q_take;
  wire [15:0] q_addr = buf_valid_reg ? buf_addr_reg : addr_reg;
  wire [7:0]  q_data = buf_valid_reg ? buf_data_reg : data_reg;
  wire       seq_nxt = (q_addr == nxt_a);
  wire       new_row = (q_addr[ROW_BITS-1:0] == {ROW_BITS{1'b0}});
  wire       blank_end = scan_pend_reg & scan_last_reg;
  wire       ccf_next = cbef_reg & idle & ~launch & ~go;       // RL8
  wire [2:0] int_ev = {set_acc, set_pv, ccf_next & ~ccf_reg};

  // ****************************************************************
  // flash clock divider
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      div_cnt_reg <= 7'h00;
      tick_reg    <= 1'b0;
    end
    else if (div_cnt_reg >= div_reg)
    begin
      div_cnt_reg <= 7'h00;
      tick_reg    <= 1'b1;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 7'h01;
      tick_reg    <= 1'b0;
    end
  end

  // ****************************************************************
  // software registers and status flags
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      div_reg      <= `FCC_RST_DIV;
      div_init_reg <= 1'b0;
      prot_reg     <= `FCC_RST_PROT;
      cmd_reg      <= `FCC_RST_CMD;
      cmd_wr_reg   <= 1'b0;
      addr_reg     <= 16'h0000;
      data_reg     <= 8'h00;
      pviol_reg    <= 1'b0;
      accerr_reg   <= 1'b0;
      ccf_reg      <= 1'b1;
      int_stat_reg <= 3'h0;
      int_mask_reg <= `FCC_RST_MASK;
      o_irq        <= 1'b0;
    end
    else
    begin
      if (we && i_awaddr == `FCC_OFS_DIV && !div_init_reg)
      begin
        div_reg      <= wd[6:0];
        div_init_reg <= 1'b1;
      end
      if (we && i_awaddr == `FCC_OFS_PROT)
        prot_reg <= wd;
      if (w_seq && cbef_reg)
      begin
        if (i_awaddr == `FCC_OFS_CMD)
        begin
          cmd_reg    <= wd;
          cmd_wr_reg <= 1'b1;
        end
        if (i_awaddr == `FCC_OFS_ADDR)
          addr_reg <= i_wdata[15:0];
        if (i_awaddr == `FCC_OFS_DATA)
          data_reg <= wd;
      end
      if (launch)
        cmd_wr_reg <= 1'b0;
      if (set_pv)
        pviol_reg <= 1'b1;                                     // RL9
      else if (w_stat && wd[`FCC_ST_PVIOL_BIT])
        pviol_reg <= 1'b0;
      if (set_acc)
        accerr_reg <= 1'b1;                                    // RL10
      else if (w_stat && wd[`FCC_ST_ACCERR_BIT])
        accerr_reg <= 1'b0;
      ccf_reg <= ccf_next;                                     // RL8
      if (we && i_awaddr == `FCC_OFS_INT_MASK)
        int_mask_reg <= wd[2:0];
      if (we && i_awaddr == `FCC_OFS_INT_STAT)
        int_stat_reg <= (int_stat_reg & ~wd[2:0]) | int_ev;
      else
        int_stat_reg <= int_stat_reg | int_ev;
      o_irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      state_reg     <= ST_IDLE;
      act_cmd_reg   <= 8'h00;
      timer_reg     <= 16'h0000;
      cbef_reg      <= 1'b1;
      blank_reg     <= 1'b0;
      buf_valid_reg <= 1'b0;
      buf_addr_reg  <= 16'h0000;
      buf_data_reg  <= 8'h00;
      scan_pend_reg <= 1'b0;
      scan_last_reg <= 1'b0;
      scan_ok_reg   <= 1'b1;
      o_array_addr  <= 16'h0000;
      o_array_wdata <= 8'h00;
      o_array_prog  <= 1'b0;
      o_array_erase <= 1'b0;
      o_array_mass  <= 1'b0;
      o_hv_on       <= 1'b0;
      o_pump_on     <= 1'b0;
    end
    else if (i_stop_req && !idle)
    begin
      state_reg     <= ST_IDLE;
      cbef_reg      <= 1'b1;
      buf_valid_reg <= 1'b0;
      scan_pend_reg <= 1'b0;
      o_array_prog  <= 1'b0;
      o_array_erase <= 1'b0;
      o_array_mass  <= 1'b0;
      o_hv_on       <= 1'b0;
      o_pump_on     <= 1'b0;
    end
    else
    begin
      if (go)
        blank_reg <= 1'b0;                                     // RL11
      if (go && idle)
      begin
        act_cmd_reg   <= cmd_reg;
        o_array_addr  <= is_blank ? 16'h0000 : addr_reg;
        o_array_wdata <= data_reg;
        scan_ok_reg   <= 1'b1;
        scan_pend_reg <= 1'b0;
        scan_last_reg <= 1'b0;
        if (is_blank)
          state_reg <= ST_BLANK;
        else
        begin
          state_reg     <= ST_RUN;
          o_array_prog  <= is_byte | is_burst;
          o_array_erase <= is_page;
          o_array_mass  <= is_mass;
          o_hv_on       <= 1'b1;
          o_pump_on     <= 1'b1;
          timer_reg     <= is_page ? T_PAGE[15:0] :
                           is_mass ? T_MASS[15:0] : T_STD;     // RL1
        end
      end
      else if (go)
      begin
        cbef_reg      <= 1'b0;                                 // RL7
        buf_valid_reg <= 1'b1;
        buf_addr_reg  <= addr_reg;
        buf_data_reg  <= data_reg;
      end
      case (state_reg)
        ST_RUN:
        begin
          if (tick_reg && timer_reg != 16'h0001)
            timer_reg <= timer_reg - 16'h0001;
          if (run_end && q_valid)
          begin
            buf_valid_reg <= 1'b0;
            cbef_reg      <= 1'b1;                             // RL6
            o_array_addr  <= q_addr;
            o_array_wdata <= q_data;
            if (seq_nxt && !new_row)
              timer_reg <= T_BURST;                            // RL1
            else
              timer_reg <= T_STD;                              // RL1
            if (seq_nxt && new_row)
            begin
              o_hv_on   <= 1'b0;                               // RL2
              o_array_prog <= 1'b0;
              state_reg <= ST_GAP;
            end
          end
          else if (run_end)
          begin
            state_reg     <= ST_IDLE;
            o_array_prog  <= 1'b0;
            o_array_erase <= 1'b0;
            o_array_mass  <= 1'b0;
            o_hv_on       <= 1'b0;                             // RL3
            o_pump_on     <= 1'b0;                             // RL3
          end
        end
        ST_GAP:
        begin
          o_hv_on      <= 1'b1;                                // RL2
          o_array_prog <= 1'b1;
          state_reg    <= ST_RUN;
        end
        ST_BLANK:
        begin
          scan_pend_reg <= ~blank_end;
          scan_last_reg <= (o_array_addr == LAST_A);
          if (o_array_addr != LAST_A)
            o_array_addr <= nxt_a;
          if (scan_pend_reg && i_array_rdata != `FCC_ERASED_BYTE)
            scan_ok_reg <= 1'b0;
          if (blank_end)
          begin
            state_reg <= ST_IDLE;
            blank_reg <= scan_ok_reg &
                         (i_array_rdata == `FCC_ERASED_BYTE);  // RL11
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @*
  begin
    rd_val = 8'h00;
    case (i_araddr)
      `FCC_OFS_DIV:      rd_val = {div_init_reg, div_reg};
      `FCC_OFS_PROT:     rd_val = prot_reg;
      `FCC_OFS_STAT:     rd_val = {cbef_reg, ccf_reg, pviol_reg,
                                   accerr_reg, 1'b0, blank_reg, 2'b00};
      `FCC_OFS_CMD:      rd_val = cmd_reg;
      `FCC_OFS_ADDR:     rd_val = addr_reg[7:0];
      `FCC_OFS_DATA:     rd_val = data_reg;
      `FCC_OFS_INT_STAT: rd_val = {5'h00, int_stat_reg};
      `FCC_OFS_INT_MASK: rd_val = {5'h00, int_mask_reg};
      default:           rd_val = 8'h00;
    endcase
  end

  function mapped;
    input [7:0] a;
    begin
      mapped = (a[1:0] == 2'b00) && (a <= `FCC_OFS_INT_MASK);
    end
  endfunction

  // ****************************************************************
  // axi4-lite handshakes
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_b)
    begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'b00;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rresp   <= 2'b00;
      o_rdata   <= 32'h00000000;
    end
    else
    begin
      o_awready <= i_awvalid & i_wvalid & ~o_bvalid & ~o_awready;
      o_wready  <= i_awvalid & i_wvalid & ~o_bvalid & ~o_awready;
      if (wr_do)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= mapped(i_awaddr) ? 2'b00 : 2'b10;
      end
      else if (i_bready)
        o_bvalid <= 1'b0;
      o_arready <= i_arvalid & ~o_rvalid & ~o_arready;
      if (rd_do)
      begin
        o_rvalid <= 1'b1;
        o_rresp  <= mapped(i_araddr) ? 2'b00 : 2'b10;
        if (i_araddr == `FCC_OFS_ADDR)
          o_rdata <= {16'h0000, addr_reg};
        else
          o_rdata <= {24'h000000, rd_val};
      end
      else if (i_rready)
        o_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ===== verif/fcc_flash_properties.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// port checker
// ****************************************************************
module fcc_flash_properties (
  input wire logic        i_clk_sys,
  input wire logic        i_rst_b,
  input wire logic        i_awvalid,
  input wire logic        i_wvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        i_rready,
  input wire logic        i_stop_req,
  input wire logic        o_awready,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        o_array_prog,
  input wire logic        o_array_erase,
  input wire logic        o_array_mass,
  input wire logic        o_hv_on,
  input wire logic        o_pump_on
);
  default clocking dck @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  a_wr_ready_pair: assert property (o_awready == o_wready)
    else $error("write readies apart");
  a_wr_gets_resp: assert property (
    o_awready && i_awvalid && i_wvalid |=> o_bvalid)
    else $error("no write response");
  a_bresp_holds: assert property (
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  a_rd_gets_data: assert property (o_arready && i_arvalid |=> o_rvalid)
    else $error("no read data");
  a_rdata_holds: assert property (
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  a_no_wr_busy: assert property (o_bvalid |-> !o_awready)
    else $error("write taken while answering");
  a_hv_needs_pump:
    assert property (o_hv_on |-> o_pump_on)
    else $error("high voltage without pump");
  a_row_gap_one:
    assert property ($fell(o_hv_on) && o_pump_on |=> o_hv_on)
    else $error("row gap too long");
  a_stop_aborts:
    assert property (i_stop_req |-> ##[1:3]
      !(o_array_prog || o_array_erase || o_array_mass))
    else $error("stop did not abort");
  a_single_op:
    assert property (!(o_array_prog && o_array_erase))
    else $error("program and erase together");

  c_row_gap: cover property ($fell(o_hv_on) && o_pump_on);
  c_stop: cover property (i_stop_req && o_array_mass);
  c_slverr: cover property (o_bvalid && o_bresp == 2'b10);
endmodule

bind fcc_flash_command_controller fcc_flash_properties u_props (
  .i_clk_sys, .i_rst_b, .i_awvalid, .i_wvalid, .i_bready, .i_arvalid,
  .i_rready, .i_stop_req, .o_awready, .o_wready, .o_bresp, .o_bvalid,
  .o_arready, .o_rdata, .o_rvalid, .o_array_prog, .o_array_erase,
  .o_array_mass, .o_hv_on, .o_pump_on);
`default_nettype wire

// ===== verif/fcc_flash_array_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// flash array stand-in
// ****************************************************************
module fcc_flash_array_model #(
  parameter int BYTES = 16
) (
  input  wire logic        i_clk_sys,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_prog,
  input  wire logic        i_erase,
  input  wire logic        i_mass,
  input  wire logic        i_hv_on,
  output var  logic [7:0]  o_rdata
);
  logic [7:0] mem [0:BYTES-1];

  initial
  begin
    for (int i = 0; i < BYTES; i++)
      mem[i] = 8'h00;
  end

  // cells change only under high voltage
  always @(posedge i_clk_sys)
  begin
    if (i_hv_on && (i_erase || i_mass))
      for (int i = 0; i < BYTES; i++)
        mem[i] <= 8'hFF;
    else if (i_hv_on && i_prog)
      mem[i_addr % BYTES] <= mem[i_addr % BYTES] & i_wdata;
    o_rdata <= mem[i_addr % BYTES];
  end
endmodule
`default_nettype wire

// ===== verif/fcc_flash_command_controller_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "fcc_flash_regs.vh"
module fcc_flash_command_controller_test;
  logic        i_clk_sys = 0;
  logic        i_rst_b = 0;
  logic [7:0]  i_awaddr = 0;
  logic        i_awvalid = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0]  i_wstrb = 4'hF;
  logic        i_wvalid = 0;
  logic        i_bready = 0;
  logic [7:0]  i_araddr = 0;
  logic        i_arvalid = 0;
  logic        i_rready = 0;
  logic        i_stop_req = 0;
  wire  [7:0]  i_array_rdata;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  wire  [15:0] o_array_addr;
  wire  [7:0]  o_array_wdata;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire         o_array_prog, o_array_erase, o_array_mass;
  wire         o_hv_on, o_pump_on, o_irq;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          gaps = 0;
  int          pc [0:255];
  logic [31:0] v;
  logic [1:0]  resp;
  logic        irq_a;
  logic [7:0]  p, c, e;
  logic [15:0] a;
  // prot, command, address, status after completion
  logic [39:0] rows [0:10] = '{
    40'hFF_20_0003_C0, 40'hFF_25_0005_C0, 40'hFF_05_0000_C0,
    40'hFF_40_0000_C0, 40'h02_20_0400_E0, 40'h02_20_0200_C0,
    40'h02_41_0000_E0, 40'h03_20_0400_C0, 40'hFF_33_0000_D0,
    40'hFF_41_0000_C0, 40'hFF_05_0000_C4};

  fcc_flash_command_controller #(.ARRAY_BYTES(16), .T_PAGE(5), .T_MASS(8))
  u_dut (.i_clk_sys, .i_rst_b, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
    .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_stop_req, .i_array_rdata, .o_array_addr, .o_array_wdata,
    .o_array_prog, .o_array_erase, .o_array_mass, .o_hv_on, .o_pump_on,
    .o_irq);

  fcc_flash_array_model #(.BYTES(16)) u_mem (.i_clk_sys,
    .i_addr(o_array_addr), .i_wdata(o_array_wdata), .i_prog(o_array_prog),
    .i_erase(o_array_erase), .i_mass(o_array_mass), .i_hv_on(o_hv_on),
    .o_rdata(i_array_rdata));

  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, s, x);
    end
  endtask

  task wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_awaddr <= ad;
    i_wdata <= d;
    i_awvalid <= 1;
    i_wvalid <= 1;
    i_bready <= 1;
    do @(negedge i_clk_sys); while (o_awready !== 1'b1);
    @(posedge i_clk_sys);
    i_awvalid <= 0;
    i_wvalid <= 0;
    do @(negedge i_clk_sys); while (o_bvalid !== 1'b1);
    resp = o_bresp;
    @(posedge i_clk_sys);
    i_bready <= 0;
  endtask

  task rd(input logic [7:0] ad);
    @(posedge i_clk_sys);
    i_araddr <= ad;
    i_arvalid <= 1;
    i_rready <= 1;
    do @(negedge i_clk_sys); while (o_arready !== 1'b1);
    @(posedge i_clk_sys);
    i_arvalid <= 0;
    do @(negedge i_clk_sys); while (o_rvalid !== 1'b1);
    v = o_rdata;
    resp = o_rresp;
    @(posedge i_clk_sys);
    i_rready <= 0;
  endtask

  // address and data, then code, then launch
  task launch(input logic [7:0] cd, input logic [15:0] ad);
    wr(`FCC_OFS_ADDR, {16'h0, ad});
    wr(`FCC_OFS_DATA, 32'h5A);
    wr(`FCC_OFS_CMD, {24'h0, cd});
    wr(`FCC_OFS_STAT, 32'h80);
  endtask

  task wait_idle;
    do rd(`FCC_OFS_STAT); while (v[7:6] !== 2'b11);
  endtask

  task end_sim;
    $display("checked %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // clock, monitor and timeout
  // ****************************************************************
  initial
  begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  always @(negedge i_clk_sys)
  begin
    cyc++;
    if (o_array_prog)
      pc[o_array_addr[7:0]]++;
    if (o_pump_on && !o_hv_on)
      gaps++;
    if (cyc == 6000)
    begin
      num_errors++;
      end_sim;
    end
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1;
    rd(`FCC_OFS_PROT);
    chk(v, 32'hFF);
    rd(`FCC_OFS_STAT);
    chk(v, 32'hC0);
    launch(8'h20, 16'h0003);
    wait_idle;
    chk(v, 32'hD0);
    wr(`FCC_OFS_STAT, 32'h30);
    rd(`FCC_OFS_STAT);
    chk(v, 32'hC0);
    wr(`FCC_OFS_DIV, 32'h09);
    wr(`FCC_OFS_STAT, 32'h80);
    wait_idle;
    chk(v, 32'hD0);
    wr(`FCC_OFS_STAT, 32'h30);
    $display("reset and sequence tests done");
    for (int i = 0; i < 11; i++)
    begin
      {p, c, a, e} = rows[i];
      wr(`FCC_OFS_PROT, {24'h0, p});
      launch(c, a);
      wait_idle;
      chk(v, {24'h0, e});
      wr(`FCC_OFS_STAT, 32'h30);
      $display("row %0d done", i);
    end
    wr(`FCC_OFS_STAT, 32'h00);
    rd(`FCC_OFS_STAT);
    chk(v, 32'hC4);
    launch(8'h25, 16'h003E);
    launch(8'h25, 16'h003F);
    rd(`FCC_OFS_STAT);
    chk(v[7], 1'b0);
    do rd(`FCC_OFS_STAT); while (v[7] !== 1'b1);
    launch(8'h25, 16'h0040);
    wait_idle;
    chk(v, 32'hC0);
    chk({o_pump_on, o_hv_on}, 2'b00);
    chk(pc[8'h3E] inside {[81:91]}, 1'b1);
    chk(pc[8'h3F] inside {[31:41]}, 1'b1);
    chk(pc[8'h40] inside {[81:91]}, 1'b1);
    chk(gaps, 1);
    $display("burst test done");
    launch(8'h41, 16'h0000);
    i_stop_req <= 1;
    repeat (2) @(posedge i_clk_sys);
    i_stop_req <= 0;
    wait_idle;
    chk(v, 32'hD0);
    rd(`FCC_OFS_INT_STAT);
    chk(v[2], 1'b1);
    wr(`FCC_OFS_INT_MASK, 32'h0);
    @(negedge i_clk_sys);
    irq_a = o_irq;
    wr(`FCC_OFS_INT_MASK, 32'h7);
    @(negedge i_clk_sys);
    chk(irq_a, 1'b0);
    chk(o_irq, 1'b1);
    wr(`FCC_OFS_INT_STAT, 32'h7);
    @(negedge i_clk_sys);
    chk(o_irq, 1'b0);
    rd(`FCC_OFS_INT_STAT);
    chk(v, 32'h0);
    $display("stop and interrupt test done");
    rd(8'h20);
    chk(resp, 2'b10);
    chk(v, 32'h0);
    wr(8'h22, 32'hFF);
    chk(resp, 2'b10);
    $display("unmapped test done");
    i_rst_b <= 0;
    i_wstrb <= 4'h0;
    repeat (5) @(posedge i_clk_sys);
    i_rst_b <= 1;
    wr(`FCC_OFS_DIV, 32'h09);
    i_wstrb <= 4'hF;
    rd(`FCC_OFS_DIV);
    chk(v, 32'h0);
    rd(`FCC_OFS_STAT);
    chk(v, 32'hC0);
    $display("second reset test done");
    end_sim;
  end
endmodule
`default_nettype wire
